//--- hw/rvt_vector_lookup.sv
`include "rvt_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rvt_vector_lookup #(
	parameter int AW = 20
) (
	// clock and reset
	input  wire logic                    sys_clk_in,
	input  wire logic                    rst_in,
	// table placement and global enable
	input  wire logic [AW-1:0]           vector_table_base_in,
	input  wire logic                    i_flag_in,
	// source selection and serial modes
	input  wire rvt_pkg::rvt_share_sel_t slot6_source_select_in,
	input  wire rvt_pkg::rvt_share_sel_t slot7_source_select_in,
	input  wire logic                    serial4_or_ext5_select_in,
	input  wire logic                    serial3_or_ext4_select_in,
	input  wire logic [2:0]              i2c_mode_in,
	input  wire logic [2:0]              home_bus_mode_in,
	// peripheral events
	input  wire logic [5:0]              ext_irq_in,
	input  wire logic [4:0]              atimer_in,
	input  wire logic [5:0]              btimer_in,
	input  wire logic                    slicer_on_event_in,
	input  wire logic                    remote_event_in,
	input  wire logic                    line_sync_event_in,
	input  wire logic                    clocked_serial_three_in,
	input  wire logic                    clocked_serial_four_in,
	input  wire logic [1:0]              dma_done_in,
	input  wire logic                    key_in,
	input  wire logic                    adc_done_in,
	input  wire logic [2:0]              ser_tx_in,
	input  wire logic [2:0]              ser_rx_in,
	input  wire logic [2:0]              ser_nack_in,
	input  wire logic [2:0]              ser_ack_in,
	input  wire logic [2:0]              ser_coll_in,
	input  wire logic [2:0]              ser_startstop_in,
	// fetch requests from the core sequencer
	input  wire logic                    brk_req_in,
	input  wire logic                    swi_req_in,
	input  wire logic [5:0]              swi_num_in,
	input  wire logic                    hw_take_in,
	input  wire logic [4:0]              hw_num_in,
	// vector memory reads
	input  wire logic [15:0]             mem_rdata_in,
	input  wire logic                    mem_ack_in,
	output logic                         mem_rd_out,
	output logic                         mem_word_out,
	output logic [AW-1:0]                mem_addr_out,
	// results
	output logic [31:0]                  hw_req_out,
	output logic                         busy_out,
	output logic                         fetch_done_out,
	output logic [5:0]                   fetch_num_out,
	output logic [31:0]                  vector_out
);
	import rvt_pkg::*;

	// serial channel order on slots 15..20 is 2, 0, 1
	localparam logic [1:0] SER_ORDER [3] = '{2'd2, 2'd0, 2'd1};

	logic [2:0]  tx_cause;
	logic [2:0]  rx_cause;
	logic [2:0]  coll_cause;
	logic [31:0] src;
	logic [31:0] next_hw_req;

	genvar ch;
	generate
		for (ch = 0; ch < 3; ch++) begin : g_ser
			assign tx_cause[ch]   = i2c_mode_in[ch] ? ser_nack_in[ch] : ser_tx_in[ch];
			assign rx_cause[ch]   = i2c_mode_in[ch] ? ser_ack_in[ch] : ser_rx_in[ch];
			// outside both bus modes the collision detector is not a cause
			assign coll_cause[ch] = i2c_mode_in[ch] ? ser_startstop_in[ch] :
				(home_bus_mode_in[ch] & ser_coll_in[ch]);
			assign src[`RVT_NUM_SER_FIRST + 2*ch]     = tx_cause[SER_ORDER[ch]];
			assign src[`RVT_NUM_SER_FIRST + 2*ch + 1] = rx_cause[SER_ORDER[ch]];
		end
		for (ch = 0; ch < 5; ch++) begin : g_ta
			assign src[`RVT_NUM_TA_FIRST + ch] = atimer_in[ch];
		end
		for (ch = 0; ch < 3; ch++) begin : g_tb
			assign src[`RVT_NUM_TB_FIRST + ch] = btimer_in[ch];
			assign src[`RVT_NUM_EXT_FIRST + ch] = ext_irq_in[ch];
		end
	endgenerate

	// breakpoint is instruction driven, slots 1..3 reserved
	assign src[3:0] = 4'h0;
	assign src[`RVT_NUM_EXT3] = ext_irq_in[3];
	assign src[`RVT_NUM_TB5]  = btimer_in[5] | slicer_on_event_in;
	assign src[`RVT_NUM_SHARE6] =
		(slot6_source_select_in == RVT_SEL_TIMER) ? btimer_in[4] :
		(slot6_source_select_in == RVT_SEL_EVENT) ? remote_event_in :
		(slot6_source_select_in == RVT_SEL_COLL)  ? coll_cause[1] : 1'b0;
	assign src[`RVT_NUM_SHARE7] =
		(slot7_source_select_in == RVT_SEL_TIMER) ? btimer_in[3] :
		(slot7_source_select_in == RVT_SEL_EVENT) ? line_sync_event_in :
		(slot7_source_select_in == RVT_SEL_COLL)  ? coll_cause[0] : 1'b0;
	assign src[`RVT_NUM_SHARE8] = serial4_or_ext5_select_in ? ext_irq_in[5] :
		clocked_serial_four_in;
	assign src[`RVT_NUM_SHARE9] = serial3_or_ext4_select_in ? ext_irq_in[4] :
		clocked_serial_three_in;
	assign src[`RVT_NUM_COLL2] = coll_cause[2];
	assign src[`RVT_NUM_DMA0]  = dma_done_in[0];
	assign src[`RVT_NUM_DMA1]  = dma_done_in[1];
	assign src[`RVT_NUM_KEY]   = key_in;
	assign src[`RVT_NUM_ADC]   = adc_done_in;

	assign next_hw_req = src & {32{i_flag_in}};

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hw_req_out <= 32'h0;
		end else begin
			hw_req_out <= next_hw_req;
		end
	end

	// fetch sequencing
	rvt_state_t  state;
	rvt_state_t  next_state;
	logic [AW-1:0] base_lat;
	logic [1:0]  idx;
	logic        byte_mode;
	logic        start;
	logic [5:0]  start_num;
	logic [7:0]  start_off;
	logic [AW-1:0] start_addr;
	logic [1:0]  last_idx;
	logic        last_beat;
	logic [AW-1:0] step;
	logic [31:0] next_vector;

	// software paths bypass the enable flag, hardware path does not
	assign start     = (state == RVT_IDLE) &
		(brk_req_in | swi_req_in | (hw_take_in & i_flag_in));
	assign start_num = brk_req_in ? `RVT_NUM_BRK :
		swi_req_in ? swi_num_in : {1'b0, hw_num_in};
	assign start_off = {start_num, 2'b00};
	assign start_addr = vector_table_base_in + AW'(start_off);
	// an odd base forces byte reads; even base reads whole words
	assign last_idx  = byte_mode ? 2'd3 : 2'd1;
	assign last_beat = mem_ack_in & (idx == last_idx);
	assign step      = byte_mode ? AW'(1) : AW'(2);

	always_comb begin
		next_vector = vector_out;
		if (state == RVT_READ && mem_ack_in) begin
			if (byte_mode) begin
				next_vector[idx*8 +: 8] = mem_rdata_in[7:0];
			end else begin
				next_vector[idx[0]*16 +: 16] = mem_rdata_in;
			end
		end
	end

	always_comb begin
		case (state)
			RVT_IDLE: next_state = start ? RVT_READ : RVT_IDLE;
			RVT_READ: next_state = last_beat ? RVT_DONE : RVT_READ;
			RVT_DONE: next_state = RVT_IDLE;
			default:  next_state = RVT_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= RVT_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			base_lat     <= '0;
			byte_mode    <= 1'b0;
			idx          <= 2'd0;
			fetch_num_out <= 6'h0;
			mem_addr_out <= '0;
		end else if (start) begin
			base_lat     <= vector_table_base_in;
			byte_mode    <= vector_table_base_in[0];
			idx          <= 2'd0;
			fetch_num_out <= start_num;
			mem_addr_out <= start_addr;
		end else if (state == RVT_READ && mem_ack_in) begin
			idx          <= idx + 2'd1;
			mem_addr_out <= mem_addr_out + step;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mem_rd_out     <= 1'b0;
			mem_word_out   <= 1'b0;
			busy_out       <= 1'b0;
			fetch_done_out <= 1'b0;
			vector_out     <= `RVT_RESET_VECTOR;
		end else begin
			mem_rd_out     <= start | (state == RVT_READ && !last_beat);
			mem_word_out   <= start ? !vector_table_base_in[0] : mem_word_out;
			busy_out       <= (next_state != RVT_IDLE);
			fetch_done_out <= (state == RVT_READ) & last_beat;
			vector_out     <= next_vector;
		end
	end

	// checks
	logic [2:0] beats;
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			beats <= 3'd0;
		end else if (start) begin
			beats <= 3'd0;
		end else if (state == RVT_READ && mem_ack_in) begin
			beats <= beats + 3'd1;
		end
	end

	a_reserved_quiet: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		hw_req_out[3:1] == 3'b000)
		else $error("reserved slot raised by hardware");

	a_mask_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!i_flag_in |=> hw_req_out == 32'h0)
		else $error("maskable request passed with flag clear");

	a_brk_slot: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == RVT_IDLE && brk_req_in) |=>
		fetch_num_out == 6'h00 && mem_addr_out == base_lat)
		else $error("breakpoint not on slot zero");

	a_in_table: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		mem_rd_out |-> (mem_addr_out - base_lat) < AW'(`RVT_TABLE_BYTES))
		else $error("vector read outside table");

	a_addr_offset: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		start |=> mem_addr_out == $past(vector_table_base_in) + AW'({$past(start_num), 2'b00}))
		else $error("vector address not base plus offset");

	a_beat_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$rose(fetch_done_out) |-> beats == (byte_mode ? 3'd4 : 3'd2))
		else $error("wrong number of reads for base parity");

	a_word_mode: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		mem_rd_out |-> mem_word_out == !base_lat[0])
		else $error("read width does not follow base parity");

	a_ext3_slot: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(ext_irq_in[3] && i_flag_in) |=> hw_req_out[4])
		else $error("external three not on slot four");

	a_slot5_or: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		i_flag_in |=> hw_req_out[5] == $past(btimer_in[5] | slicer_on_event_in))
		else $error("slot five not timer or slicer");

	a_slot6_timer: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(i_flag_in && slot6_source_select_in == RVT_SEL_TIMER) |=>
		hw_req_out[6] == $past(btimer_in[4]))
		else $error("slot six not following its timer");

	a_slot7_none: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		slot7_source_select_in == RVT_SEL_NONE |=> !hw_req_out[7])
		else $error("slot seven raised with no source chosen");

	a_share8_ext: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(i_flag_in && serial4_or_ext5_select_in) |=> hw_req_out[8] == $past(ext_irq_in[5]))
		else $error("slot eight not following external five");

	a_share9_serial: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(i_flag_in && !serial3_or_ext4_select_in) |=>
		hw_req_out[9] == $past(clocked_serial_three_in))
		else $error("slot nine not following serial three");

	a_key_slot: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		i_flag_in |=> hw_req_out[13] == $past(key_in))
		else $error("key input not on slot thirteen");

	a_adc_slot: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		i_flag_in |=> hw_req_out[14] == $past(adc_done_in))
		else $error("conversion end not on slot fourteen");

	a_ch2_tx_slot: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(i_flag_in && !i2c_mode_in[2]) |=> hw_req_out[15] == $past(ser_tx_in[2]))
		else $error("channel two transmit not on slot fifteen");

	a_i2c_tx: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(i2c_mode_in[0] && i_flag_in) |=> hw_req_out[17] == $past(ser_nack_in[0]))
		else $error("i2c transmit slot not following nack");

	a_i2c_rx: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(i2c_mode_in[1] && i_flag_in) |=> hw_req_out[20] == $past(ser_ack_in[1]))
		else $error("i2c receive slot not following ack");

	a_timer_a0: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		i_flag_in |=> hw_req_out[21] == $past(atimer_in[0]))
		else $error("first a-timer not on slot twenty-one");

	a_timer_b2: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		i_flag_in |=> hw_req_out[28] == $past(btimer_in[2]))
		else $error("third b-timer not on slot twenty-eight");

	a_ext0_slot: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		i_flag_in |=> hw_req_out[29] == $past(ext_irq_in[0]))
		else $error("external zero not on slot twenty-nine");

	a_sw_high: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == RVT_IDLE && swi_req_in && !brk_req_in && swi_num_in[5]) |=>
		(mem_addr_out - base_lat) >= AW'(`RVT_SW_OFFSET))
		else $error("software vector below upper half");

	a_coll2_i2c: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(i_flag_in && i2c_mode_in[2]) |=> hw_req_out[10] == $past(ser_startstop_in[2]))
		else $error("collision slot not following start or stop");

	a_done_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		fetch_done_out |=> !fetch_done_out && !busy_out)
		else $error("done not a single pulse");

	a_swi_num: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == RVT_IDLE && swi_req_in && !brk_req_in) |=>
		fetch_num_out == $past(swi_num_in))
		else $error("software fetch number not taken");

endmodule : rvt_vector_lookup

`default_nettype wire

//--- hw/rvt_params.svh
`ifndef RVT_PARAMS_SVH
`define RVT_PARAMS_SVH

`define RVT_TABLE_BYTES   256
`define RVT_VEC_BYTES     4
`define RVT_NUM_BRK       6'h00
`define RVT_NUM_EXT3      5'h04
`define RVT_NUM_TB5       5'h05
`define RVT_NUM_SHARE6    5'h06
`define RVT_NUM_SHARE7    5'h07
`define RVT_NUM_SHARE8    5'h08
`define RVT_NUM_SHARE9    5'h09
`define RVT_NUM_COLL2     5'h0a
`define RVT_NUM_DMA0      5'h0b
`define RVT_NUM_DMA1      5'h0c
`define RVT_NUM_KEY       5'h0d
`define RVT_NUM_ADC       5'h0e
`define RVT_NUM_SER_FIRST 5'h0f
`define RVT_NUM_TA_FIRST  5'h15
`define RVT_NUM_TB_FIRST  5'h1a
`define RVT_NUM_EXT_FIRST 5'h1d
`define RVT_NUM_SW_FIRST  6'h20
`define RVT_SW_OFFSET     8'h80
`define RVT_RESET_VECTOR  32'h0000_0000

`endif

//--- hw/rvt_pkg.sv
package rvt_pkg;

	typedef enum logic [1:0] {
		RVT_IDLE = 2'b00,
		RVT_READ = 2'b01,
		RVT_DONE = 2'b10
	} rvt_state_t;

	typedef enum logic [1:0] {
		RVT_SEL_TIMER  = 2'b00,
		RVT_SEL_EVENT  = 2'b01,
		RVT_SEL_COLL   = 2'b10,
		RVT_SEL_NONE   = 2'b11
	} rvt_share_sel_t;

endpackage : rvt_pkg

//--- testbench/rvt_tb_pkg.sv
package rvt_tb_pkg;
	// contents depend on every address bit, so a wrong slot or base shows up
	function automatic logic [7:0] tbl_byte(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ {a[19:16], 4'h9};
	endfunction : tbl_byte
	function automatic logic [31:0] tbl_vec(input logic [19:0] a);
		return {tbl_byte(a + 20'h3), tbl_byte(a + 20'h2), tbl_byte(a + 20'h1), tbl_byte(a)};
	endfunction : tbl_vec
endpackage : rvt_tb_pkg

//--- testbench/rvt_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module rvt_mem_model (
	// clock, reset, answer delay
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic [3:0]  lat_in,
	// vector reads
	input  wire logic        rd_in,
	input  wire logic [19:0] addr_in,
	output logic             ack_out,
	output logic [15:0]      rdata_out
);
	import rvt_tb_pkg::*;
	logic [3:0]  cnt;
	logic [15:0] data;
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in || !rd_in || ack_out) begin
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
	assign ack_out   = rd_in && (cnt == lat_in);
	assign data      = {tbl_byte(addr_in + 20'h1), tbl_byte(addr_in)};
	// inverted outside ack so stale data never passes for valid
	assign rdata_out = ack_out ? data : ~data;
endmodule : rvt_mem_model
`default_nettype wire

//--- testbench/relocatable_vector_table_lookup_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module relocatable_vector_table_lookup_tb_top;
	import rvt_pkg::*;
	import rvt_tb_pkg::*;
	logic sys_clk_in = 1'b0, rst_in = 1'b1, i_flag = 1'b0, armed = 1'b0;
	logic breakpoint_instruction = 1'b0, swi = 1'b0, hw = 1'b0;
	logic [5:0] swi_num = 6'h00, ext = 6'h00, bt = 6'h00;
	logic [4:0] hw_num = 5'h00, at = 5'h00;
	logic [19:0] base = 20'h00000;
	logic [3:0] lat = 4'h0;
	logic [63:0] rs = 64'h28;
	logic [1:0] dma = 2'h0;
	logic sl = 1'b0, rc = 1'b0, ls = 1'b0, s3 = 1'b0, s4 = 1'b0;
	logic key = 1'b0, adc = 1'b0, q8 = 1'b0, q9 = 1'b0;
	logic [2:0] tx = 3'h0, rx = 3'h0, nk = 3'h0, ak = 3'h0;
	logic [2:0] co = 3'h0, ss = 3'h0, i2c = 3'h0, hbr = 3'h0;
	rvt_share_sel_t s6 = RVT_SEL_NONE, s7 = RVT_SEL_NONE;
	wire logic [2:0] hb = hbr & ~i2c;
	logic mem_rd_out, mem_word_out, mem_ack, busy_out, fetch_done_out;
	logic [19:0] mem_addr_out;
	logic [15:0] mem_rdata;
	logic [31:0] hw_req_out, vector_out, e_q;
	logic [5:0] fetch_num_out;
	int bad_count = 0, compares = 0, cyc = 0;

	always #50 sys_clk_in = ~sys_clk_in;

	function automatic logic [63:0] xs(input logic [63:0] x);
		x ^= x << 13;
		x ^= x >> 7;
		x ^= x << 17;
		return x;
	endfunction : xs
	function automatic logic sel(input rvt_share_sel_t s, input logic a, b, c);
		return s == RVT_SEL_TIMER ? a : s == RVT_SEL_EVENT ? b : s == RVT_SEL_COLL ? c : 1'b0;
	endfunction : sel
	function automatic logic [31:0] exp_req();
		logic [31:0] e;
		logic [2:0] cs, tv, rv;
		cs = (i2c & ss) | (hb & co);
		tv = (i2c & nk) | (~i2c & tx);
		rv = (i2c & ak) | (~i2c & rx);
		e = {ext[2:0], bt[2:0], at, rv[1], tv[1], rv[0], tv[0], rv[2], tv[2], adc, key, dma,
			cs[2], q9 ? ext[4] : s3, q8 ? ext[5] : s4, sel(s7, bt[3], ls, cs[0]),
			sel(s6, bt[4], rc, cs[1]), bt[5] | sl, ext[3], 4'h0};
		return i_flag ? e : 32'h0;
	endfunction : exp_req
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report
	// kind 0 breakpoint, 1 software, 2 maskable
	task automatic fetch(input int kind, input logic [5:0] num, input logic [19:0] b,
		input logic [3:0] l);
		int n;
		logic [5:0] en;
		en = (kind == 0) ? 6'h00 : (kind == 2) ? {1'b0, num[4:0]} : num;
		n = 0;
		@(posedge sys_clk_in);
		base <= b;
		lat <= l;
		breakpoint_instruction <= (kind == 0);
		swi <= (kind == 1);
		hw <= (kind == 2);
		swi_num <= num;
		hw_num <= num[4:0];
		@(posedge sys_clk_in);
		{breakpoint_instruction, swi, hw} <= 3'h0;
		#1 chk({31'h0, busy_out}, 32'h1);
		chk({12'h0, mem_addr_out}, {12'h0, b + {12'h0, en, 2'b00}});
		do begin
			@(posedge sys_clk_in);
			#1 n++;
		end while (fetch_done_out !== 1'b1 && n < 100);
		chk(32'(n), 32'((b[0] ? 4 : 2) * (l + 1)));
		chk({26'h0, fetch_num_out}, {26'h0, en});
		chk(vector_out, tbl_vec(b + {12'h0, en, 2'b00}));
	endtask : fetch

	always @(posedge sys_clk_in) begin
		rs <= xs(rs);
		{ext, at, bt, sl, rc, ls, s3, s4, dma, key, adc, tx, rx, nk, ak, co, ss, i2c, hbr, q8, q9}
			<= rs[51:0];
		s6 <= rvt_share_sel_t'(rs[53:52]);
		s7 <= rvt_share_sel_t'(rs[55:54]);
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			final_report();
		end
	end
	always @(negedge sys_clk_in) begin
		if (armed) chk(hw_req_out & 32'h3ff, e_q & 32'h3ff);
		if (armed) chk(hw_req_out & 32'h1f_fc00, e_q & 32'h1f_fc00);
		if (armed) chk(hw_req_out & 32'hffe0_0000, e_q & 32'hffe0_0000);
		if (mem_rd_out) chk({31'h0, mem_word_out}, {31'h0, !base[0]});
		e_q = exp_req();
		armed = !rst_in;
	end

	rvt_vector_lookup DUT (.sys_clk_in, .rst_in, .vector_table_base_in(base), .i_flag_in(i_flag),
		.slot6_source_select_in(s6), .slot7_source_select_in(s7),
		.serial4_or_ext5_select_in(q8), .serial3_or_ext4_select_in(q9), .i2c_mode_in(i2c),
		.home_bus_mode_in(hb), .ext_irq_in(ext), .atimer_in(at), .btimer_in(bt),
		.slicer_on_event_in(sl), .remote_event_in(rc), .line_sync_event_in(ls),
		.clocked_serial_three_in(s3), .clocked_serial_four_in(s4), .dma_done_in(dma),
		.key_in(key), .adc_done_in(adc), .ser_tx_in(tx), .ser_rx_in(rx), .ser_nack_in(nk),
		.ser_ack_in(ak), .ser_coll_in(co), .ser_startstop_in(ss), .brk_req_in(breakpoint_instruction),
		.swi_req_in(swi), .swi_num_in(swi_num), .hw_take_in(hw), .hw_num_in(hw_num),
		.mem_rdata_in(mem_rdata), .mem_ack_in(mem_ack), .mem_rd_out, .mem_word_out,
		.mem_addr_out, .hw_req_out, .busy_out, .fetch_done_out, .fetch_num_out, .vector_out);
	rvt_mem_model MEM (.sys_clk_in, .rst_in, .lat_in(lat), .rd_in(mem_rd_out),
		.addr_in(mem_addr_out), .ack_out(mem_ack), .rdata_out(mem_rdata));

	initial begin
		repeat (10) @(posedge sys_clk_in);
		chk({busy_out, fetch_done_out, mem_rd_out, hw_req_out[28:0]}, 32'h0);
		rst_in <= 1'b0;
		i_flag <= 1'b1;
		fetch(0, 6'h00, 20'h00000, 4'h0);
		fetch(1, 6'h3f, 20'hfff00, 4'h2);
		for (int k = 0; k < 64; k++) fetch(1, 6'(k), {rs[19:1], k[0]}, 4'(k % 3));
		for (int k = 0; k < 40; k++) fetch(int'(rs[1:0]) % 3, rs[9:4], rs[29:10], {2'h0, rs[31:30]});
		// a maskable request with the enable low must not start a fetch
		@(posedge sys_clk_in);
		i_flag <= 1'b0;
		hw <= 1'b1;
		hw_num <= 5'h04;
		@(posedge sys_clk_in);
		hw <= 1'b0;
		@(posedge sys_clk_in);
		#1 chk({30'h0, busy_out, mem_rd_out}, 32'h0);
		fetch(0, 6'h00, 20'h00301, 4'h1);
		fetch(1, 6'h21, 20'h00302, 4'h0);
		final_report();
	end
endmodule : relocatable_vector_table_lookup_tb_top
`default_nettype wire
